//--- shared/agcf_pkg.sv
// constants and state layout of the agc loop feedback filter
package agcf_pkg;

  // register byte offsets, one aligned word each
  localparam logic [4:0] OFS_LOOP = 5'h00;
  localparam logic [4:0] OFS_MODE = 5'h04;
  localparam logic [4:0] OFS_TARGET = 5'h08;
  localparam logic [4:0] OFS_LIMIT = 5'h0C;
  localparam logic [4:0] OFS_BRESET = 5'h10;
  localparam logic [4:0] OFS_ACCUM = 5'h14;
  localparam logic [4:0] OFS_ERR = 5'h18;

  // field positions
  localparam int unsigned MANT0_LSB = 0;
  localparam int unsigned EXP0_LSB = 4;
  localparam int unsigned MANT1_LSB = 8;
  localparam int unsigned EXP1_LSB = 12;
  localparam int unsigned RETAIN_BIT = 15;
  localparam int unsigned MEDIAN_BIT = 16;
  localparam int unsigned LIM_MIN_LSB = 0;
  localparam int unsigned LIM_MAX_LSB = 16;

  // datapath widths and alignment
  localparam int unsigned TGT_W = 13;
  localparam int unsigned ERR_W = 14;
  localparam int unsigned LIM_W = 12;
  localparam int unsigned ACC_W = 32;
  localparam int unsigned GAIN_W = 16;
  localparam int unsigned GAIN_MSB = 30;
  localparam logic [3:0] SHIFT_MAX = 4'hF;

  // fixed median errors, sign extended to the error width
  localparam logic signed [13:0] MED_POS = 14'sh0200;
  localparam logic signed [13:0] MED_NEG = 14'sh3C00;

  // reset values
  localparam logic [15:0] LOOP_RST = 16'h0000;
  localparam logic [12:0] TARGET_RST = 13'h0000;
  localparam logic [11:0] LIM_MAX_RST = 12'hFFF;
  localparam logic [11:0] LIM_MIN_RST = 12'h000;

  // software settings
  typedef struct packed {
    logic [15:0] loop_param;
    logic retain;
    logic median;
    logic [12:0] target;
    logic [11:0] lim_max;
    logic [11:0] lim_min;
  } agcf_cfg_t;

  // all state of the filter
  typedef struct packed {
    agcf_cfg_t cfg;
    logic sync_m;
    logic sync_s;
    logic sync_d;
    logic sel_m;
    logic sel_s;
    logic signed [31:0] accum;
    logic [15:0] gain;
    logic gain_valid;
    logic signed [13:0] err;
    logic wreq;
    logic [31:0] rdata;
  } agcf_state_t;

  localparam agcf_cfg_t CFG_RST = '{loop_param: LOOP_RST, retain: 1'b0,
    median: 1'b0, target: TARGET_RST, lim_max: LIM_MAX_RST,
    lim_min: LIM_MIN_RST};
  localparam agcf_state_t ST_RST = '{cfg: CFG_RST, wreq: 1'b1,
    default: '0};

endpackage

//--- rtl/agcf_loop_filter.sv
// agc loop feedback filter: error detector, scaling and limited accumulator
`timescale 1ns/10ps
module agcf_loop_filter #(
  parameter int MAG_W = 13
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [MAG_W-1:0] mag_i,
  input wire logic mag_valid_i,
  input wire logic loop_gain_select_input_i,
  input wire logic second_sync_input_i,
  output logic [15:0] gain_o,
  output logic gain_valid_o
);

  // magnitude may not be wider than the target level
  if (MAG_W < 1 || MAG_W > agcf_pkg::TGT_W) begin : g_chk
    $error("agcf_loop_filter: MAG_W must be 1 to 13");
  end

  agcf_pkg::agcf_state_t st; // registered state
  agcf_pkg::agcf_state_t next_st; // next state

  logic req; // bus request present
  logic take; // request accepted at this edge
  logic bres_wr; // write to the backend reset word
  logic sync_evt; // rising edge of the second sync input
  logic clear; // accumulator clear this cycle
  logic upd; // accumulator update this cycle
  logic [3:0] mant; // selected loop gain mantissa
  logic [3:0] expo; // selected loop gain exponent
  logic signed [13:0] err; // true gain error
  logic signed [13:0] use_err; // error fed to the scaler
  logic signed [18:0] prod; // error times mantissa
  logic signed [31:0] aligned; // product at accumulator weight
  logic signed [31:0] delta; // scaled error after the shift
  logic signed [32:0] sum; // unlimited accumulator sum
  logic signed [32:0] max_w; // upper limit at accumulator weight
  logic signed [32:0] min_w; // lower limit at accumulator weight
  logic signed [31:0] limited; // sum after limiting

  // merge a write into a word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // place a 12-bit gain limit at accumulator weight
  function automatic logic signed [32:0] lim_word(input logic [11:0] lim);
    return {2'b00, lim, 19'h00000};
  endfunction

  // settings as seen on the bus
  function automatic logic [31:0] cfg_word(input agcf_pkg::agcf_cfg_t c,
                                           input logic [4:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      agcf_pkg::OFS_LOOP: begin
        r[15:0] = c.loop_param;
      end
      agcf_pkg::OFS_MODE: begin
        r[agcf_pkg::RETAIN_BIT] = c.retain;
        r[agcf_pkg::MEDIAN_BIT] = c.median;
      end
      agcf_pkg::OFS_TARGET: begin
        r[12:0] = c.target;
      end
      agcf_pkg::OFS_LIMIT: begin
        r[agcf_pkg::LIM_MAX_LSB +: 12] = c.lim_max;
        r[agcf_pkg::LIM_MIN_LSB +: 12] = c.lim_min;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  // next state of the whole filter
  always_comb begin
    next_st = st;

    // two-flop synchronisers for the pins
    next_st.sync_m = second_sync_input_i;
    next_st.sync_s = st.sync_m;
    next_st.sync_d = st.sync_s;
    next_st.sel_m = loop_gain_select_input_i;
    next_st.sel_s = st.sel_m;
    sync_evt = st.sync_s & ~st.sync_d;

    // bus: one wait cycle, then the request is taken
    req = read_i | write_i;
    take = req & ~st.wreq;
    next_st.wreq = ~(req & st.wreq);
    bres_wr = take & write_i & (address_i == agcf_pkg::OFS_BRESET);

    // read data is latched while waitrequest is still high
    if (req & st.wreq & read_i) begin
      unique case (address_i)
        agcf_pkg::OFS_ACCUM: begin
          next_st.rdata = st.accum;
        end
        agcf_pkg::OFS_ERR: begin
          next_st.rdata = {{18{st.err[13]}}, st.err};
        end
        default: begin
          next_st.rdata = cfg_word(st.cfg, address_i);
        end
      endcase
    end

    // register writes take effect at the accepting edge
    if (take & write_i) begin
      unique case (address_i)
        agcf_pkg::OFS_LOOP: begin
          // both mantissa/exponent pairs
          next_st.cfg.loop_param = 16'(be_merge({16'h0000,
                                                 st.cfg.loop_param},
                                                writedata_i,
                                                byteenable_i));
        end
        agcf_pkg::OFS_MODE: begin
          // retain and median bits
          if (byteenable_i[1]) begin
            next_st.cfg.retain = writedata_i[agcf_pkg::RETAIN_BIT];
          end
          if (byteenable_i[2]) begin
            next_st.cfg.median = writedata_i[agcf_pkg::MEDIAN_BIT];
          end
        end
        agcf_pkg::OFS_TARGET: begin
          next_st.cfg.target = 13'(be_merge({19'h00000, st.cfg.target},
                                            writedata_i, byteenable_i));
        end
        agcf_pkg::OFS_LIMIT: begin
          if (byteenable_i[0]) begin
            next_st.cfg.lim_min[7:0] = writedata_i[7:0];
          end
          if (byteenable_i[1]) begin
            next_st.cfg.lim_min[11:8] = writedata_i[11:8];
          end
          if (byteenable_i[2]) begin
            next_st.cfg.lim_max[7:0] = writedata_i[23:16];
          end
          if (byteenable_i[3]) begin
            next_st.cfg.lim_max[11:8] = writedata_i[27:24];
          end
        end
        default: begin
          // read-only, strobe-only and unmapped words ignore data
        end
      endcase
    end

    // error detector
    err = $signed({1'b0, st.cfg.target})
          - $signed({1'b0, agcf_pkg::TGT_W'(mag_i)});

    // median mode keeps only the sign of the error
    if (st.cfg.median) begin
      use_err = err[13] ? agcf_pkg::MED_NEG : agcf_pkg::MED_POS;
    end else begin
      // mean mode keeps the proportional error
      use_err = err;
    end

    // gain pair chosen by the synchronised select pin
    if (st.sel_s) begin
      mant = st.cfg.loop_param[agcf_pkg::MANT1_LSB +: 4];
      expo = st.cfg.loop_param[agcf_pkg::EXP1_LSB +: 4];
    end else begin
      mant = st.cfg.loop_param[agcf_pkg::MANT0_LSB +: 4];
      expo = st.cfg.loop_param[agcf_pkg::EXP0_LSB +: 4];
    end

    // mantissa weight code/16
    prod = use_err * $signed({1'b0, mant});
    aligned = {{2{prod[18]}}, prod, 11'h000};
    // exponent shift of 15-code places
    delta = aligned >>> (agcf_pkg::SHIFT_MAX - expo);

    // accumulate and limit
    sum = {st.accum[31], st.accum} + {delta[31], delta};
    max_w = lim_word(st.cfg.lim_max);
    min_w = lim_word(st.cfg.lim_min);
    if (sum > max_w) begin
      limited = max_w[31:0];
    end else if (sum < min_w) begin
      limited = min_w[31:0];
    end else begin
      limited = sum[31:0];
    end

    // one update per magnitude sample
    upd = mag_valid_i;
    // fixed-size median steps make the gain dither
    if (upd) begin
      next_st.accum = limited;
      next_st.err = err;
    end

    // reset events
    clear = sync_evt | (bres_wr & ~st.cfg.retain);
    if (clear) begin
      next_st.accum = 32'sh0000_0000;
    end

    // gain control follows the accumulator
    next_st.gain = next_st.accum[agcf_pkg::GAIN_MSB -: agcf_pkg::GAIN_W];
    next_st.gain_valid = upd;
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= agcf_pkg::ST_RST;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign readdata_o = st.rdata;
  assign waitrequest_o = st.wreq;
  assign gain_o = st.gain;
  assign gain_valid_o = st.gain_valid;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // code zero gives no movement at all
  property p_mant_zero;
    upd && !st.cfg.median && mant == 4'h0 |-> delta == 32'sh0000_0000;
  endproperty
  a_mant_zero: assert property (p_mant_zero)
    else $error("zero mantissa moved the accumulator");

  // unit mantissa, no shift: error lands at weight 2^11
  property p_unit_scale;
    upd && !st.cfg.median && mant == 4'h1 && expo == 4'hF
      |-> delta == ($signed({{18{err[13]}}, err}) <<< 11);
  endproperty
  a_unit_scale: assert property (p_unit_scale)
    else $error("unit loop gain scaled the error wrongly");

  // exponent zero: fifteen more places of attenuation
  property p_exp_zero;
    upd && !st.cfg.median && mant == 4'h1 && expo == 4'h0
      |-> delta == ($signed({{18{err[13]}}, err}) >>> 4);
  endproperty
  a_exp_zero: assert property (p_exp_zero)
    else $error("exponent zero did not shift fifteen places");

  // median step for mantissa 8, no shift, either error sign
  property p_median_step;
    upd && st.cfg.median && mant == 4'h8 && expo == 4'hF
      |-> delta == (err[13] ? -32'sh0100_0000 : 32'sh0080_0000);
  endproperty
  a_median_step: assert property (p_median_step)
    else $error("median step has the wrong size or sign");

  // clearing reset word empties the accumulator
  property p_clear;
    ce_i && bres_wr && !st.cfg.retain |=> st.accum == 32'sh0000_0000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("backend reset did not clear the accumulator");

  // retained accumulator survives the backend reset word
  property p_retain;
    ce_i && bres_wr && st.cfg.retain && !upd && !sync_evt
      |=> st.accum == $past(st.accum);
  endproperty
  a_retain: assert property (p_retain)
    else $error("retained accumulator changed on backend reset");

  // an update never leaves the programmed limits while lim_min <= lim_max
  property p_limits;
    ce_i && upd && !clear && st.cfg.lim_min <= st.cfg.lim_max
      |=> st.accum <= $past(max_w) && st.accum >= $past(min_w);
  endproperty
  a_limits: assert property (p_limits)
    else $error("accumulator outside the gain limits");

  // gain output and its strobe follow one update
  property p_update;
    ce_i && upd && !clear
      |=> gain_valid_o && gain_o == $past(limited[30:15]);
  endproperty
  a_update: assert property (p_update)
    else $error("gain output missed an update");

  // a waiting request is answered at the next enabled edge
  property p_bus_answer;
    ce_i && req && waitrequest_o |=> !waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered after one wait cycle");

  // sync pin event always empties the accumulator
  property p_sync_clear;
    ce_i && sync_evt |=> st.accum == 32'sh0000_0000;
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("sync event did not clear the accumulator");

  // median steps keep the error's direction and vanish only for mantissa zero
  property p_median_dir;
    upd && st.cfg.median && mant != 4'h0
      |-> delta != 32'sh0000_0000 && delta[31] == err[13];
  endproperty
  a_median_dir: assert property (p_median_dir)
    else $error("median step lost its direction");

  // full loop gain scales the fixed median errors
  property p_median_gain;
    upd && st.cfg.median && mant == 4'hF && expo == 4'hF
      |-> delta == (err[13] ? -32'sh01E0_0000 : 32'sh00F0_0000);
  endproperty
  a_median_gain: assert property (p_median_gain)
    else $error("median error not scaled by the loop gain");

  // mantissa 3, exponent 12: error moves the sum by 768 per unit
  property p_mean_scale;
    upd && !st.cfg.median && mant == 4'h3 && expo == 4'hC
      |-> delta == $signed({{18{err[13]}}, err}) * 32'sh0000_0300;
  endproperty
  a_mean_scale: assert property (p_mean_scale)
    else $error("mean mode error not scaled proportionally");

endmodule

//--- tb/agcf_far_end.sv
// far-end model: magnitude source and the two control pins
`timescale 1ns/10ps
module agcf_far_end (
  input wire logic clk_i,
  output logic [12:0] mag_o,
  output logic mag_valid_o,
  output logic sel_o,
  output logic sync_o
);
  // idle levels at time zero
  initial begin
    mag_o = 13'h0000;
    mag_valid_o = 1'b0;
    sel_o = 1'b0;
    sync_o = 1'b0;
  end
  // one sample; afterwards the bus shows the inverse, not a stale copy
  task automatic sample(input logic [12:0] m);
    @(posedge clk_i);
    mag_o <= m;
    mag_valid_o <= 1'b1;
    @(posedge clk_i);
    mag_valid_o <= 1'b0;
    mag_o <= ~m;
  endtask
  // fast pair at burst start, slow pair for tracking
  task automatic pick(input logic s);
    @(posedge clk_i);
    sel_o <= s;
    repeat (4) @(posedge clk_i);
  endtask
  // sync pin pulse, long enough for the synchroniser
  task automatic pulse_sync();
    @(posedge clk_i);
    sync_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sync_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

//--- tb/tb_agc_loop_feedback_filter.sv
// testbench of the agc loop feedback filter
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_agc_loop_feedback_filter;
  logic clk_i, sys_rst_i, read, write, waitrequest_o, gain_valid_o;
  logic [4:0] address;
  logic [31:0] wdata, readdata_o, q, q1;
  logic [15:0] gain_o;
  logic [12:0] mag;
  logic mag_valid, sel_pin, sync_pin;
  int errors = 0, checks_done = 0, cyc = 0;
  // reference copy of the settings and the accumulator
  logic [15:0] loop_w = 16'h0000;
  logic [31:0] mode = 32'h0;
  logic [12:0] tgt = 13'h1000;
  logic [11:0] lmax = 12'hFFF, lmin = 12'h000;
  logic sel = 1'b0;
  logic signed [31:0] acc = 32'sh0;
  logic [7:0] tab [6] = '{8'hFF, 8'hF8, 8'h0F, 8'hF0, 8'hC5, 8'h01};

  agcf_far_end P (.clk_i(clk_i), .mag_o(mag), .mag_valid_o(mag_valid),
    .sel_o(sel_pin), .sync_o(sync_pin));
  agcf_loop_filter DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .address_i(address), .read_i(read), .write_i(write),
    .writedata_i(wdata), .byteenable_i(4'hF), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .mag_i(mag), .mag_valid_i(mag_valid),
    .loop_gain_select_input_i(sel_pin), .second_sync_input_i(sync_pin),
    .gain_o(gain_o), .gain_valid_o(gain_valid_o));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic test_done();
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    address <= a;
    write <= w;
    read <= !w;
    wdata <= d;
    do begin
      @(posedge clk_i);
    end while (waitrequest_o !== 1'b0);
    r = readdata_o;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // program all settings from the reference copy
  task automatic cfg();
    bus(1, agcf_pkg::OFS_LOOP, {16'h0, loop_w}, q);
    bus(1, agcf_pkg::OFS_MODE, mode, q);
    bus(1, agcf_pkg::OFS_TARGET, {19'h0, tgt}, q);
    bus(1, agcf_pkg::OFS_LIMIT, {4'h0, lmax, 4'h0, lmin}, q);
  endtask
  // predict one update, send the sample, check the output
  task automatic upd(input logic [12:0] m);
    logic signed [13:0] e;
    logic [7:0] p;
    longint d, s, hi, lo;
    e = $signed({1'b0, tgt}) - $signed({1'b0, m});
    if (mode[16]) begin
      e = (e >= 0) ? agcf_pkg::MED_POS : agcf_pkg::MED_NEG;
    end
    p = sel ? loop_w[15:8] : loop_w[7:0];
    d = longint'(e) * longint'(p[3:0]);
    d = d <<< 11;
    d = d >>> (15 - p[7:4]);
    hi = longint'(lmax) <<< 19;
    lo = longint'(lmin) <<< 19;
    s = longint'(acc) + d;
    if (s > hi) s = hi;
    if (s < lo) s = lo;
    acc = s[31:0];
    P.sample(m);
    #1;
    `CHK("gain", acc[30:15], gain_o)
    `CHK("gain_valid", 1'b1, gain_valid_o)
  endtask
  // reset values, unmapped offset reads zero
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      bus(0, 5'(i * 4), 32'h0, q);
      `CHK("reset_reg", (i == 3) ? 32'h0FFF0000 : 32'h0, q)
    end
  endtask
  // mean mode over a table of gain codes, both error signs
  task automatic t_mean();
    for (int i = 0; i < 6; i++) begin
      loop_w = {8'h00, tab[i]};
      cfg();
      upd(13'h0000);
      upd(13'h0000);
      upd(13'h1800);
      bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q);
      `CHK("accum_mean", acc, q)
    end
  endtask
  // second gain pair under the select pin
  task automatic t_sel();
    loop_w = 16'hC3F1;
    cfg();
    P.pick(1'b1);
    sel = 1'b1;
    upd(13'h0000);
    P.pick(1'b0);
    sel = 1'b0;
    upd(13'h0000);
  endtask
  // median mode: fixed step by sign, dithering, bounded step
  task automatic t_median();
    mode = 32'h0001_0000;
    loop_w = 16'h00FF;
    cfg();
    bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q1);
    upd(13'h0000);
    bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q);
    `CHK("step", 1'b1, $signed(q - q1) <= 32'sh02000000)
    loop_w = 16'h00F8;
    cfg();
    upd(13'h1FFF);
    upd(13'h0FFF);
    upd(13'h1001);
    bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q);
    `CHK("accum_median", acc, q)
    bus(0, agcf_pkg::OFS_ERR, 32'h0, q);
    `CHK("err_word", 32'hFFFFFFFF, q)
  endtask
  // clamp at both limits
  task automatic t_limit();
    mode = 32'h0;
    lmax = 12'h010;
    lmin = 12'h008;
    cfg();
    upd(13'h0000);
    upd(13'h0000);
    upd(13'h1FFF);
    upd(13'h1FFF);
    upd(13'h1FFF);
  endtask
  // backend reset with and without retain, sync pin clear
  task automatic t_breset();
    lmax = 12'hFFF;
    lmin = 12'h000;
    cfg();
    upd(13'h0000);
    bus(1, agcf_pkg::OFS_ACCUM, 32'h1234, q);
    bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q);
    `CHK("accum_ro", acc, q)
    bus(1, agcf_pkg::OFS_BRESET, 32'h1, q);
    acc = 32'sh0;
    bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q);
    `CHK("breset_clear", acc, q)
    upd(13'h0000);
    mode = 32'h0000_8000;
    cfg();
    bus(1, agcf_pkg::OFS_BRESET, 32'h1, q);
    bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q);
    `CHK("breset_keep", acc, q)
    P.pulse_sync();
    acc = 32'sh0;
    bus(0, agcf_pkg::OFS_ACCUM, 32'h0, q);
    `CHK("sync_clear", acc, q)
    `CHK("sync_gain", 16'h0000, gain_o)
  endtask
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    wdata = 32'h0;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_mean();
    t_sel();
    t_median();
    t_limit();
    t_breset();
    test_done();
  end
endmodule
